// ---- hdl/tsq_regs.svh ----
// Purpose: Offsets, field positions, option codes and reset values of the trigger sequencer step options block.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per aligned word.
// Notes:   Definitions only.
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TSQ_OFF_CTRL    8'h00
`define TSQ_OFF_BTE     8'h04
`define TSQ_OFF_HOLD    8'h08
`define TSQ_OFF_ADJ     8'h0c
`define TSQ_OFF_LIM0    8'h10
`define TSQ_OFF_LIM5    8'h24
`define TSQ_OFF_CNT0    8'h28
`define TSQ_OFF_CNT1    8'h2c
`define TSQ_OFF_CHSEL   8'h30
`define TSQ_OFF_STATUS  8'h34

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TSQ_CTRL_SWTRIG 0
`define TSQ_STAT_SDEN   5
`define TSQ_REG_RESET   16'h0000
`define TSQ_NUM_LIM     6

// ----------------------------------------------------------------------------
// Option codes
// ----------------------------------------------------------------------------
`define TSQ_OPT_SDOFF   4'h2
`define TSQ_OPT_SDON    4'h6
`define TSQ_OPT_TMR0    4'h8
`define TSQ_OPT_TMR1    4'h9
`define TSQ_OPT_SWWAIT  4'hb
`define TSQ_OPT_CH_C0   4'hc
`define TSQ_OPT_CH_C1   4'hd
`define TSQ_OPT_CH_L0   4'he
`define TSQ_OPT_BCAST   4'hf
`define TSQ_OPT_LASTLIM 3'h5

`endif

// ---- hdl/tsq_pkg.sv ----
// Purpose: Types shared by the trigger sequencer step options block.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Numbers live in tsq_regs.svh; this package holds types only.
package tsq_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_TMR0 = 5'h02,
        ST_TMR1 = 5'h04,
        ST_SWT  = 5'h08,
        ST_DLY  = 5'h10
    } tsq_state_t;

    // Step command codes; add and copy share one code, option bit 3 picks copy.
    typedef enum logic [3:0] {
        CMD_CTRL  = 4'h1,
        CMD_LIMIT = 4'h5
    } tsq_cmd_t;

    // Index of each limit register in the limit array.
    typedef enum logic [2:0] {
        LIM_CNT0 = 3'h0,
        LIM_CNT1 = 3'h1,
        LIM_TMR0 = 3'h2,
        LIM_TMR1 = 3'h3,
        LIM_SDLY = 3'h4,
        LIM_LIT0 = 3'h5
    } tsq_lim_t;

endpackage

// ---- hdl/tsq_step_options.sv ----
// Purpose: Executes the option field of trigger control, limit add and limit copy steps.
// Assumes: One 100 MHz clock mclk, asynchronous active-low reset rstn, steps come from logic on mclk.
// Notes:   Registers sit on an AHB-Lite slave with zero wait states and always answer OKAY.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`include "tsq_regs.svh"

module tsq_step_options (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Step stream.
    input  wire logic        stepValid,
    input  wire logic [3:0]  stepCmd,
    input  wire logic [3:0]  stepOpt,
    output logic             stepReady,
    // Outputs to the peripherals.
    output logic      [15:0] trigOut,
    output logic      [15:0] chanSel
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    tsq_pkg::tsq_state_t stateReg;          // Sequencer state.
    tsq_pkg::tsq_state_t stateNext;         // Next sequencer state.
    logic [15:0] limReg [`TSQ_NUM_LIM];     // Limit and literal registers.
    logic [15:0] bteReg;                    // Broadcast trigger enable.
    logic [15:0] holdReg;                   // Hold value for copy steps.
    logic [15:0] adjReg;                    // Adjust value for add steps.
    logic [15:0] cnt0Reg;                   // Counter 0 value.
    logic [15:0] cnt1Reg;                   // Counter 1 value.
    logic        swTrigReg;                 // Software trigger bit.
    logic        swPrevReg;                 // Software trigger bit one cycle ago.
    logic        sdEnReg;                   // Step delay timer enable.
    logic        sdEnNext;                  // Step delay enable after this cycle.
    logic [15:0] waitCnt;                   // Shared timer and delay count.
    logic        waitDone;                  // Count has met the active limit.
    logic [15:0] waitLim;                   // Limit of the active wait.
    logic        stepGo;                    // A step is taken this cycle.
    logic        isCtrl;                    // Taken step is a control step.
    logic        isLim;                     // Taken step is an add or copy step.
    logic        limHit;                    // Add or copy names a real target.
    logic        swRise;                    // Software trigger rose this cycle.
    logic        waitEnd;                   // A wait state is finishing.
    logic        dpWrite;                   // A write data phase is under way.
    logic [7:0]  dpAddr;                    // Address of that write.
    logic        apValid;                   // An address phase is taken.
    logic [7:0]  apAddr;                    // Address phase word offset.
    logic [31:0] rdMux;                     // Read value for the address phase.
    logic        bcastGo;                   // A broadcast step is taken this cycle.

    // ------------------------------------------------------------------------
    // Step decode
    // ------------------------------------------------------------------------
    // A step is taken only in the idle state, so waits hold off the next one.
    assign stepReady = (stateReg == tsq_pkg::ST_IDLE);
    assign stepGo    = stepValid && stepReady;
    assign isCtrl    = stepGo && (stepCmd == tsq_pkg::CMD_CTRL);
    assign isLim     = stepGo && (stepCmd == tsq_pkg::CMD_LIMIT);
    // Add codes 0-5 and copy codes 8-13 hit a target, others do nothing.
    assign limHit    = isLim && (stepOpt[2:0] <= `TSQ_OPT_LASTLIM);
    // The history resets to the bit's idle level, so leaving reset makes no false rise.
    assign swRise    = swTrigReg && !swPrevReg;
    // Broadcast decode, shared by the trigger register and its check.
    assign bcastGo   = isCtrl && (stepOpt == `TSQ_OPT_BCAST);

    // Enable flag that the following steps will see.
    always_comb begin
        sdEnNext = sdEnReg;
        if (isCtrl && stepOpt == `TSQ_OPT_SDOFF) begin
            sdEnNext = 1'b0;
        end else if (isCtrl && stepOpt == `TSQ_OPT_SDON) begin
            sdEnNext = 1'b1;
        end
    end

    // Step delay enable register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sdEnReg <= 1'b0;
        end else begin
            sdEnReg <= sdEnNext;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------------------
    // Limit that the running wait is measured against.
    always_comb begin
        case (stateReg)
            tsq_pkg::ST_TMR0: waitLim = limReg[tsq_pkg::LIM_TMR0];
            tsq_pkg::ST_TMR1: waitLim = limReg[tsq_pkg::LIM_TMR1];
            default:          waitLim = limReg[tsq_pkg::LIM_SDLY];
        endcase
    end
    assign waitDone = (waitCnt == waitLim);
    assign waitEnd  = (stateReg == tsq_pkg::ST_SWT) ? swRise : waitDone;

    // Next state: waits leave when their condition holds, then the delay if it is enabled.
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            tsq_pkg::ST_IDLE: begin
                if (isCtrl && stepOpt == `TSQ_OPT_TMR0) begin
                    stateNext = tsq_pkg::ST_TMR0;
                end else if (isCtrl && stepOpt == `TSQ_OPT_TMR1) begin
                    stateNext = tsq_pkg::ST_TMR1;
                end else if (isCtrl && stepOpt == `TSQ_OPT_SWWAIT) begin
                    stateNext = tsq_pkg::ST_SWT;
                end else if (stepGo && sdEnNext) begin
                    stateNext = tsq_pkg::ST_DLY;
                end
            end
            tsq_pkg::ST_TMR0, tsq_pkg::ST_TMR1, tsq_pkg::ST_SWT: begin
                if (waitEnd) begin
                    stateNext = sdEnReg ? tsq_pkg::ST_DLY : tsq_pkg::ST_IDLE;
                end
            end
            tsq_pkg::ST_DLY: begin
                if (waitDone) begin
                    stateNext = tsq_pkg::ST_IDLE;
                end
            end
            default: stateNext = tsq_pkg::ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stateReg <= tsq_pkg::ST_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // Shared count restarts at zero whenever a new wait begins.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            waitCnt <= `TSQ_REG_RESET;
        end else if (stateNext != stateReg || stateReg == tsq_pkg::ST_IDLE) begin
            waitCnt <= `TSQ_REG_RESET;
        end else if (!waitDone) begin
            waitCnt <= waitCnt + 16'h0001;
        end
    end

    // Software trigger history for edge detection.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            swPrevReg <= 1'b0;
        end else begin
            swPrevReg <= swTrigReg;
        end
    end

    // ------------------------------------------------------------------------
    // Peripheral outputs
    // ------------------------------------------------------------------------
    // Channel select takes a counter or literal 0.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chanSel <= `TSQ_REG_RESET;
        end else if (isCtrl && stepOpt == `TSQ_OPT_CH_C0) begin
            chanSel <= cnt0Reg;
        end else if (isCtrl && stepOpt == `TSQ_OPT_CH_C1) begin
            chanSel <= cnt1Reg;
        end else if (isCtrl && stepOpt == `TSQ_OPT_CH_L0) begin
            chanSel <= limReg[tsq_pkg::LIM_LIT0];
        end
    end

    // Broadcast pulses every enabled trigger together for one cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trigOut <= `TSQ_REG_RESET;
        end else if (bcastGo) begin
            trigOut <= bteReg;
        end else begin
            trigOut <= `TSQ_REG_RESET;
        end
    end

    // ------------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------------
    // The slave never stalls and never reports an error.
    // Every access is taken as a whole word, so the size field is not looked at.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign apValid   = hsel && hready && htrans[1];
    assign apAddr    = {haddr[7:2], 2'b00};

    // Write data phase bookkeeping.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dpWrite <= 1'b0;
            dpAddr  <= 8'h00;
        end else if (hready) begin
            dpWrite <= apValid && hwrite && (haddr[31:8] == 24'h000000);
            dpAddr  <= apAddr;
        end
    end

    // Read value; unmapped words and upper bits read zero.
    always_comb begin
        rdMux = 32'h00000000;
        case (apAddr)
            `TSQ_OFF_CTRL:   rdMux[`TSQ_CTRL_SWTRIG] = swTrigReg;
            `TSQ_OFF_BTE:    rdMux[15:0] = bteReg;
            `TSQ_OFF_HOLD:   rdMux[15:0] = holdReg;
            `TSQ_OFF_ADJ:    rdMux[15:0] = adjReg;
            `TSQ_OFF_CNT0:   rdMux[15:0] = cnt0Reg;
            `TSQ_OFF_CNT1:   rdMux[15:0] = cnt1Reg;
            `TSQ_OFF_CHSEL:  rdMux[15:0] = chanSel;
            `TSQ_OFF_STATUS: rdMux[5:0]  = {sdEnReg, stateReg};
            default: begin
                if (apAddr >= `TSQ_OFF_LIM0 && apAddr <= `TSQ_OFF_LIM5) begin
                    rdMux[15:0] = limReg[apAddr[4:2] - 3'h4];
                end
            end
        endcase
        if (haddr[31:8] != 24'h000000) begin
            rdMux = 32'h00000000;
        end
    end

    // Read data is latched at the address phase and stands in the data phase.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (apValid && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    // Plain software registers.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            swTrigReg <= 1'b0;
            bteReg    <= `TSQ_REG_RESET;
            holdReg   <= `TSQ_REG_RESET;
            adjReg    <= `TSQ_REG_RESET;
            cnt0Reg   <= `TSQ_REG_RESET;
            cnt1Reg   <= `TSQ_REG_RESET;
        end else if (dpWrite) begin
            case (dpAddr)
                `TSQ_OFF_CTRL: swTrigReg <= hwdata[`TSQ_CTRL_SWTRIG];
                `TSQ_OFF_BTE:  bteReg    <= hwdata[15:0];
                `TSQ_OFF_HOLD: holdReg   <= hwdata[15:0];
                `TSQ_OFF_ADJ:  adjReg    <= hwdata[15:0];
                `TSQ_OFF_CNT0: cnt0Reg   <= hwdata[15:0];
                `TSQ_OFF_CNT1: cnt1Reg   <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Limit and literal registers
    // ------------------------------------------------------------------------
    // Each entry takes an add or copy step in one cycle; a step beats a bus write.
    // Software that writes a limit while steps run may see its write lost to a step.
    for (genvar i = 0; i < `TSQ_NUM_LIM; i++) begin : g_lim
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                limReg[i] <= `TSQ_REG_RESET;
            end else if (limHit && stepOpt[2:0] == 3'(i) && !stepOpt[3]) begin
                limReg[i] <= limReg[i] + adjReg;
            end else if (limHit && stepOpt[2:0] == 3'(i) && stepOpt[3]) begin
                limReg[i] <= holdReg;
            end else if (dpWrite && dpAddr == 8'(`TSQ_OFF_LIM0 + 4 * i)) begin
                limReg[i] <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // A disable step clears the enable seen by the steps that follow.
    sd_off_a: assert property (
        isCtrl && stepOpt == `TSQ_OPT_SDOFF |=> !sdEnReg)
        else $error("step delay not disabled");
    // An enable step sets the flag and is itself followed by the delay.
    sd_on_a: assert property (
        isCtrl && stepOpt == `TSQ_OPT_SDON |=> sdEnReg && stateReg == tsq_pkg::ST_DLY)
        else $error("step delay not enabled");
    // Timer 0 keeps the sequence stalled until its count meets the limit.
    tmr0_wait_a: assert property (
        stateReg == tsq_pkg::ST_TMR0 && waitCnt != limReg[tsq_pkg::LIM_TMR0] |=> stateReg == tsq_pkg::ST_TMR0)
        else $error("timer 0 wait ended early");
    // Timer 1 starts from a zero count in the cycle after the take.
    tmr1_start_a: assert property (
        isCtrl && stepOpt == `TSQ_OPT_TMR1 |=> stateReg == tsq_pkg::ST_TMR1 && waitCnt == 16'h0000)
        else $error("timer 1 wait not started");
    // The software wait is left only on a fresh rise of the trigger bit.
    sw_rise_a: assert property (
        stateReg == tsq_pkg::ST_SWT && !swRise |=> stateReg == tsq_pkg::ST_SWT)
        else $error("software wait left without a rise");
    // Channel select takes counter 0 as it stood at the take.
    chsel_c0_a: assert property (
        isCtrl && stepOpt == `TSQ_OPT_CH_C0 |=> chanSel == $past(cnt0Reg))
        else $error("channel select missed counter 0");
    // Channel select takes literal 0 as it stood at the take.
    chsel_l0_a: assert property (
        isCtrl && stepOpt == `TSQ_OPT_CH_L0 |=> chanSel == $past(limReg[5]))
        else $error("channel select missed literal 0");
    // The broadcast word stands one cycle, unless a second broadcast follows at once.
    bcast_pulse_a: assert property (
        bcastGo |=> trigOut == $past(bteReg) ##1 (trigOut == 16'h0000 || $past(bcastGo)))
        else $error("broadcast pulse wrong");
    // An add to the timer 0 limit wraps at sixteen bits.
    add_t0_a: assert property (
        isLim && stepOpt == 4'h2 |=> limReg[2] == 16'($past(limReg[2]) + $past(adjReg)))
        else $error("timer 0 limit add wrong");
    // A copy to the step delay limit takes the hold value.
    copy_sd_a: assert property (
        isLim && stepOpt == 4'hc |=> limReg[4] == $past(holdReg))
        else $error("step delay limit copy wrong");
    // A reserved add option leaves literal 0 and the counter 0 limit alone.
    reserved_nop_a: assert property (
        isLim && stepOpt == 4'h7 && !dpWrite |=> $stable(limReg[5]) && $stable(limReg[0]))
        else $error("reserved option changed state");
    // No step takes effect while a wait or the delay is running.
    busy_block_a: assert property (
        stateReg != tsq_pkg::ST_IDLE && !dpWrite
        |=> $stable(chanSel) && $stable(limReg[0]) && trigOut == 16'h0000)
        else $error("step accepted during a wait");

    // Main scenarios: a timer wait, a software wait, the delay and a broadcast.
    tmr0_done_c: cover property (stateReg == tsq_pkg::ST_TMR0 ##1 stateReg == tsq_pkg::ST_IDLE);
    sw_done_c: cover property (stateReg == tsq_pkg::ST_SWT && swRise);
    delay_c: cover property (stateReg == tsq_pkg::ST_DLY ##1 stateReg == tsq_pkg::ST_IDLE);
    bcast_c: cover property (trigOut != 16'h0000);

endmodule

// ---- tb/tsq_trig_sink.sv ----
// Purpose: Stands in for the peripherals that receive triggers and the channel select.
// Assumes: Triggers are single-cycle pulses on mclk.
// Notes:   Keeps the last nonzero trigger word and how many cycles triggers stood high.
module tsq_trig_sink (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Trigger and channel inputs.
    input  wire logic [15:0] trigOut,
    input  wire logic [15:0] chanSel,
    // Observations for the bench.
    output logic      [15:0] lastTrig,
    output logic      [15:0] lastChan,
    output int               trigCycles
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // A converter latches the channel on each trigger; the trigger word is kept as well.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lastTrig   <= 16'h0000;
            lastChan   <= 16'h0000;
            trigCycles <= 0;
        end else if (trigOut != 16'h0000) begin
            lastTrig   <= trigOut;
            lastChan   <= chanSel;
            trigCycles <= trigCycles + 1;
        end
    end
endmodule

// ---- tb/tb_trigger_sequencer_step_options.sv ----
// Purpose: Self-checking bench of the step option executor.
// Assumes: Zero-wait AHB-Lite slave; steps taken on stepValid and stepReady.
// Notes:   Registers are set and read over the bus, steps are offered one at a time.
`include "tsq_regs.svh"
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_trigger_sequencer_step_options;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk, rstn, hsel, hwrite, hreadyout, hresp, stepValid, stepReady;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [3:0]  stepCmd, stepOpt;
    logic [15:0] trigOut, chanSel, lastTrig, lastChan;
    int          trigCycles, fails, samplesChecked, n;
    logic [7:0]  badSteps [13] = '{8'h56, 8'h57, 8'h5e, 8'h5f, 8'h10, 8'h11, 8'h13,
                                   8'h14, 8'h15, 8'h17, 8'h1a, 8'h02, 8'hf8};

    tsq_step_options dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stepValid(stepValid), .stepCmd(stepCmd), .stepOpt(stepOpt),
        .stepReady(stepReady), .trigOut(trigOut), .chanSel(chanSel));
    tsq_trig_sink sink (.mclk(mclk), .rstn(rstn), .trigOut(trigOut), .chanSel(chanSel),
        .lastTrig(lastTrig), .lastChan(lastChan), .trigCycles(trigCycles));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // One bus transfer; the address phase holds until hready, then the data phase does.
    task automatic busXfer(input logic wr, input logic [7:0] off, input logic [15:0] d,
                           output logic [31:0] q);
        hsel <= 1'b1; haddr <= {24'h0, off}; htrans <= 2'b10; hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= {16'h0, d};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] off, input logic [15:0] d);
        logic [31:0] q;
        busXfer(1'b1, off, d, q);
    endtask
    // Reads one register and compares it with the expected 16-bit value.
    task automatic rdChk(input logic [7:0] off, input logic [15:0] exp, input string nm);
        logic [31:0] q;
        busXfer(1'b0, off, 16'h0, q);
        `CHK(nm, {16'h0, exp}, q)
    endtask
    // Offers a step, then counts the cycles that stepReady stays low after the take.
    task automatic doStep(input logic [3:0] cmd, input logic [3:0] opt, output int low);
        int w;
        stepValid <= 1'b1; stepCmd <= cmd; stepOpt <= opt;
        w = 0;
        do begin @(negedge mclk); w++; end while (stepReady !== 1'b1 && w < 300);
        @(posedge mclk);
        stepValid <= 1'b0;
        low = 0;
        @(negedge mclk);
        while (stepReady !== 1'b1 && low < 300) begin low++; @(negedge mclk); end
        @(posedge mclk);
        if (w >= 300 || low >= 300) fails++;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #500us;
        fails++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hwdata = '0;
        stepValid = 1'b0; stepCmd = 4'h0; stepOpt = 4'h0; fails = 0; samplesChecked = 0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdChk(`TSQ_OFF_STATUS, 16'h0001, "status after reset");
        `CHK("chanSel after reset", 16'h0000, chanSel)
        // Copies load every limit from hold, then adds put adjust on top.
        wr(`TSQ_OFF_HOLD, 16'h1234);
        wr(`TSQ_OFF_ADJ, 16'hfff0);
        for (int i = 0; i < 6; i++) begin
            doStep(4'h5, {1'b1, 3'(i)}, n);
            rdChk(8'(`TSQ_OFF_LIM0 + 4 * i), 16'h1234, "copied limit");
            doStep(4'h5, {1'b0, 3'(i)}, n);
            rdChk(8'(`TSQ_OFF_LIM0 + 4 * i), 16'h1224, "added limit");
        end
        // Reserved codes run without waiting and change nothing.
        for (int i = 0; i < 13; i++) begin
            doStep(badSteps[i][7:4], badSteps[i][3:0], n);
            `CHK("reserved step wait", 0, n)
        end
        for (int i = 0; i < 6; i++) rdChk(8'(`TSQ_OFF_LIM0 + 4 * i), 16'h1224, "limit kept");
        `CHK("chanSel kept", 16'h0000, chanSel)
        // Channel select loads from counter 0, counter 1 and literal 0.
        wr(`TSQ_OFF_CNT0, 16'h0003);
        wr(`TSQ_OFF_CNT1, 16'h0007);
        doStep(4'h1, `TSQ_OPT_CH_C0, n);
        `CHK("chanSel counter0", 16'h0003, chanSel)
        doStep(4'h1, `TSQ_OPT_CH_C1, n);
        `CHK("chanSel counter1", 16'h0007, chanSel)
        doStep(4'h1, `TSQ_OPT_CH_L0, n);
        rdChk(`TSQ_OFF_CHSEL, 16'h1224, "chanSel literal0");
        // Broadcast pulses the enabled triggers for exactly one cycle.
        wr(`TSQ_OFF_BTE, 16'ha5c3);
        doStep(4'h1, `TSQ_OPT_BCAST, n);
        repeat (2) @(posedge mclk);
        `CHK("broadcast word", 16'ha5c3, lastTrig)
        `CHK("broadcast cycles", 1, trigCycles)
        `CHK("channel at trigger", 16'h1224, lastChan)
        // Timer waits hold the sequence for limit plus one cycles.
        wr(`TSQ_OFF_LIM0 + 8'h08, 16'h0005);
        wr(`TSQ_OFF_LIM0 + 8'h0c, 16'h0002);
        doStep(4'h1, `TSQ_OPT_TMR0, n);
        `CHK("timer0 wait", 6, n)
        doStep(4'h1, `TSQ_OPT_TMR1, n);
        `CHK("timer1 wait", 3, n)
        // A trigger bit already high does not end the wait; a fresh rise does.
        wr(`TSQ_OFF_CTRL, 16'h0001);
        fork
            doStep(4'h1, `TSQ_OPT_SWWAIT, n);
            begin
                repeat (4) @(posedge mclk);
                rdChk(`TSQ_OFF_STATUS, 16'h0008, "waiting on trigger bit");
                wr(`TSQ_OFF_CTRL, 16'h0000);
                rdChk(`TSQ_OFF_STATUS, 16'h0008, "trigger bit low");
                wr(`TSQ_OFF_CTRL, 16'h0001);
            end
        join
        rdChk(`TSQ_OFF_STATUS, 16'h0001, "trigger wait over");
        // Step delay inserts limit plus one cycles after each step until disabled.
        wr(`TSQ_OFF_LIM0 + 8'h10, 16'h0003);
        doStep(4'h1, `TSQ_OPT_SDON, n);
        `CHK("delay after enable", 4, n)
        rdChk(`TSQ_OFF_STATUS, 16'h0021, "delay enabled");
        doStep(4'h5, 4'h8, n);
        `CHK("delay after copy", 4, n)
        doStep(4'h1, `TSQ_OPT_SDOFF, n);
        `CHK("delay after disable", 0, n)
        rdChk(`TSQ_OFF_STATUS, 16'h0001, "delay disabled");
        test_done();
    end
endmodule
